// File: logic/sln_pkg.sv
// Package for the serial loop node: constants, carriers and state layout
package sln_pkg;
	// ==========================================================
	// Clock and bit rates
	localparam int SLN_CLK_HZ = 200_000_000; // Node clock, 5 ns period
	localparam int SLN_BAUD_300 = 300;
	localparam int SLN_BAUD_1200 = 1200;
	localparam int SLN_BAUD_4800 = 4800;
	localparam int SLN_BAUD_9600 = 9600;
	localparam int SLN_DIVW = 20; // Width of bit-period counters
	// Clock cycles per bit for each rate
	localparam logic [19:0] SLN_DIV_300 = 20'(SLN_CLK_HZ / SLN_BAUD_300);
	localparam logic [19:0] SLN_DIV_1200 = 20'(SLN_CLK_HZ / SLN_BAUD_1200);
	localparam logic [19:0] SLN_DIV_4800 = 20'(SLN_CLK_HZ / SLN_BAUD_4800);
	localparam logic [19:0] SLN_DIV_9600 = 20'(SLN_CLK_HZ / SLN_BAUD_9600);
	// ==========================================================
	// Message and configuration fields
	localparam int SLN_RW_BIT = 7; // Second byte: 1 marks a write
	localparam int SLN_CFG_MASTER_BIT = 2; // Configuration line: 1 selects master
	localparam logic [7:0] SLN_HOP_MAX = 8'hFF; // Hop count of a read answer
	localparam logic [3:0] SLN_FRAME_SHIFTS = 4'h9; // Data bits plus stop bit
	localparam logic [1:0] SLN_LEN_WRITE = 2'h3; // Bytes in a write message
	localparam logic [1:0] SLN_LEN_READ = 2'h2; // Bytes in a read message
	localparam logic [1:0] SLN_BUF_DEPTH = 2'h2; // Answer buffer entries
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] hop; // Hop count
		logic [7:0] ab; // Write flag and local address
		logic [7:0] dat; // Data, used by writes only
	} sln_msg_s;
	typedef struct packed {
		logic [6:0] addr; // Address the answer came from
		logic [7:0] dat; // Value read
	} sln_rsp_s;
	typedef enum logic [2:0] {P_HOP, P_AB, P_DAT, P_ACT, P_SEND, P_DLV} sln_pst_e;
	// Whole state of the node
	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic [3:0] cfg_s1;
		logic [3:0] cfg_s2;
		logic rx_busy;
		logic [19:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_vld;
		logic [7:0] rx_byte;
		sln_pst_e pst;
		sln_msg_s msg;
		logic tx_busy;
		logic [19:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [8:0] tx_sh;
		logic tx_line;
		logic [1:0] tx_idx;
		logic [127:0][7:0] mem;
		logic [1:0][14:0] buf_d;
		logic buf_wr;
		logic buf_rd;
		logic [1:0] buf_cnt;
	} sln_state_s;
endpackage

// File: logic/sln_node.sv
// Serial loop node: receives, executes or forwards loop messages
`timescale 1ns/1ps
`default_nettype none
module sln_node
#(
	parameter logic [19:0] DIV_300 = sln_pkg::SLN_DIV_300, // Cycles per bit at 300
	parameter logic [19:0] DIV_1200 = sln_pkg::SLN_DIV_1200, // Cycles per bit at 1200
	parameter logic [19:0] DIV_4800 = sln_pkg::SLN_DIV_4800, // Cycles per bit at 4800
	parameter logic [19:0] DIV_9600 = sln_pkg::SLN_DIV_9600 // Cycles per bit at 9600
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] cfg_pins,
	input wire logic loop_rx,
	output logic loop_tx,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sln_pkg::sln_msg_s cmd_msg,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output sln_pkg::sln_rsp_s rsp_data
);
	import sln_pkg::*;

	// ==========================================================
	// State registers
	sln_state_s q; // Present state
	sln_state_s next_q; // Next state
	logic master; // Node is the loop master
	logic [19:0] div; // Cycles per bit for the chosen rate
	logic rx_launch; // Hop-state command take by the master
	logic tx_launch; // A byte starts on the line
	logic buf_push; // Answer enters the buffer
	logic buf_pop; // Answer leaves the buffer
	logic [1:0] nbytes; // Length of the held message
	logic [7:0] tx_byte; // Byte chosen for sending

	// Role and rate from the synchronised lines
	assign master = q.cfg_s2[SLN_CFG_MASTER_BIT];
	always_comb
	begin
		case (q.cfg_s2[1:0])
			2'h0: div = DIV_300;
			2'h1: div = DIV_1200;
			2'h2: div = DIV_4800;
			default: div = DIV_9600;
		endcase
	end

	// Message length follows the write flag
	assign nbytes = q.msg.ab[SLN_RW_BIT] ? SLN_LEN_WRITE : SLN_LEN_READ;
	always_comb
	begin
		case (q.tx_idx)
			2'h0: tx_byte = q.msg.hop;
			2'h1: tx_byte = q.msg.ab;
			default: tx_byte = q.msg.dat;
		endcase
	end

	// Handshakes
	assign cmd_ready = master && (q.pst == P_HOP) && !q.rx_vld;
	assign rx_launch = cmd_valid && cmd_ready;
	assign tx_launch = (q.pst == P_SEND) && !q.tx_busy && (q.tx_idx != nbytes);
	assign buf_push = (q.pst == P_DLV) && (q.buf_cnt != SLN_BUF_DEPTH);
	assign buf_pop = rsp_valid && rsp_ready;
	assign rsp_valid = (q.buf_cnt != 2'h0);
	assign rsp_data = q.buf_d[q.buf_rd];
	assign loop_tx = q.tx_line;

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_q = q;
		// Two-stage synchronisers for the pins
		next_q.rx_s1 = loop_rx;
		next_q.rx_s2 = q.rx_s1;
		next_q.cfg_s1 = cfg_pins;
		next_q.cfg_s2 = q.cfg_s1;
		next_q.rx_vld = 1'b0;
		// Receiver: find start edge, sample each bit at mid period
		if (!q.rx_busy)
		begin
			if (!q.rx_s2)
			begin
				next_q.rx_busy = 1'b1;
				next_q.rx_cnt = div >> 1;
				next_q.rx_bit = 4'h0;
			end
		end
		else if (q.rx_cnt != 20'h0)
		begin
			next_q.rx_cnt = q.rx_cnt - 20'h1;
		end
		else
		begin
			next_q.rx_cnt = div - 20'h1;
			next_q.rx_bit = q.rx_bit + 4'h1;
			if (q.rx_bit == 4'h0)
			begin
				// False start: line back high at mid start bit
				next_q.rx_busy = !q.rx_s2;
			end
			else if (q.rx_bit != SLN_FRAME_SHIFTS)
			begin
				next_q.rx_sh = {q.rx_s2, q.rx_sh[7:1]}; // LSB first
			end
			else
			begin
				// Stop bit: keep the byte only when framed correctly
				next_q.rx_busy = 1'b0;
				next_q.rx_vld = q.rx_s2;
				next_q.rx_byte = q.rx_sh;
			end
		end
		// Transmitter: start bit, eight data bits, stop bit
		if (tx_launch)
		begin
			next_q.tx_busy = 1'b1;
			next_q.tx_line = 1'b0;
			next_q.tx_sh = {1'b1, tx_byte};
			next_q.tx_bit = SLN_FRAME_SHIFTS;
			next_q.tx_cnt = div - 20'h1;
			next_q.tx_idx = q.tx_idx + 2'h1;
		end
		else if (q.tx_busy)
		begin
			if (q.tx_cnt != 20'h0)
			begin
				next_q.tx_cnt = q.tx_cnt - 20'h1;
			end
			else if (q.tx_bit == 4'h0)
			begin
				next_q.tx_busy = 1'b0; // Stop bit has run its period
			end
			else
			begin
				next_q.tx_line = q.tx_sh[0];
				next_q.tx_sh = {1'b1, q.tx_sh[8:1]};
				next_q.tx_bit = q.tx_bit - 4'h1;
				next_q.tx_cnt = div - 20'h1;
			end
		end
		// Message sequencer
		case (q.pst)
			P_HOP:
			begin
				if (rx_launch)
				begin
					next_q.msg = cmd_msg;
					next_q.pst = P_SEND;
				end
				else if (q.rx_vld)
				begin
					next_q.msg.hop = q.rx_byte;
					next_q.pst = P_AB;
				end
			end
			P_AB:
			begin
				if (q.rx_vld)
				begin
					next_q.msg.ab = q.rx_byte;
					next_q.msg.dat = 8'h00;
					// Third byte awaited only for writes
					next_q.pst = q.rx_byte[SLN_RW_BIT] ? P_DAT : P_ACT;
				end
			end
			P_DAT:
			begin
				if (q.rx_vld)
				begin
					next_q.msg.dat = q.rx_byte;
					next_q.pst = P_ACT;
				end
			end
			P_ACT:
			begin
				if (master)
				begin
					// Returning answers carry data; stray reads are dropped
					next_q.pst = q.msg.ab[SLN_RW_BIT] ? P_DLV : P_HOP;
				end
				else if (q.msg.hop != 8'h00)
				begin
					next_q.msg.hop = q.msg.hop - 8'h01;
					next_q.pst = P_SEND;
				end
				else if (q.msg.ab[SLN_RW_BIT])
				begin
					next_q.mem[q.msg.ab[6:0]] = q.msg.dat;
					next_q.pst = P_HOP;
				end
				else
				begin
					// Answer travels far enough to reach the master
					next_q.msg.hop = SLN_HOP_MAX;
					next_q.msg.ab[SLN_RW_BIT] = 1'b1;
					next_q.msg.dat = q.mem[q.msg.ab[6:0]];
					next_q.pst = P_SEND;
				end
			end
			P_SEND:
			begin
				if (!q.tx_busy && (q.tx_idx == nbytes))
				begin
					next_q.tx_idx = 2'h0;
					next_q.pst = P_HOP;
				end
			end
			P_DLV:
			begin
				if (buf_push)
				begin
					next_q.pst = P_HOP; // Waits here while buffer is full
				end
			end
			default: next_q.pst = P_HOP;
		endcase
		// Two-entry answer buffer
		if (buf_push)
		begin
			next_q.buf_d[q.buf_wr] = {q.msg.ab[6:0], q.msg.dat};
			next_q.buf_wr = !q.buf_wr;
		end
		if (buf_pop)
		begin
			next_q.buf_rd = !q.buf_rd;
		end
		next_q.buf_cnt = q.buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			q <= '0;
			q.rx_s1 <= 1'b1; // Idle line is high
			q.rx_s2 <= 1'b1;
			q.tx_line <= 1'b1;
		end
		else
		begin
			q <= next_q;
		end
	end

	// ==========================================================
	// Checks
	AST_WRITE_DATA: assert property (@(posedge mclk) disable iff (rst)
		(q.pst == P_AB) && q.rx_vld && q.rx_byte[SLN_RW_BIT] |=> (q.pst == P_DAT))
		else $error("write address byte did not await data");
	AST_READ_NODATA: assert property (@(posedge mclk) disable iff (rst)
		(q.pst == P_AB) && q.rx_vld && !q.rx_byte[SLN_RW_BIT] |=> (q.pst == P_ACT))
		else $error("read message awaited a data byte");
	AST_SLAVE_ACTS: assert property (@(posedge mclk) disable iff (rst)
		(q.pst == P_ACT) && !master && (q.msg.hop == 8'h00)
		|=> ($past(q.msg.ab[SLN_RW_BIT]) ? (q.pst == P_HOP) : (q.pst == P_SEND)))
		else $error("slave did not execute a zero-hop message");
	AST_FORWARD: assert property (@(posedge mclk) disable iff (rst)
		(q.pst == P_ACT) && !master && (q.msg.hop != 8'h00)
		|=> (q.pst == P_SEND) && (q.msg.hop == $past(q.msg.hop) - 8'h01))
		else $error("forwarded hop count not reduced by one");
	AST_STORE: assert property (@(posedge mclk) disable iff (rst)
		(q.pst == P_ACT) && !master && (q.msg.hop == 8'h00) && q.msg.ab[SLN_RW_BIT]
		|=> (q.mem[$past(q.msg.ab[6:0])] == $past(q.msg.dat)))
		else $error("write did not store data at address");
	AST_READ_ANSWER: assert property (@(posedge mclk) disable iff (rst)
		(q.pst == P_ACT) && !master && (q.msg.hop == 8'h00) && !q.msg.ab[SLN_RW_BIT]
		|=> (q.msg.hop == SLN_HOP_MAX) && (q.pst == P_SEND)
		&& (q.msg.dat == $past(q.mem[q.msg.ab[6:0]])))
		else $error("read answer malformed");
	AST_MASTER_ONLY: assert property (@(posedge mclk) disable iff (rst)
		!master |-> !cmd_ready && !buf_push)
		else $error("slave took a command or an answer");
	AST_START_BIT: assert property (@(posedge mclk) disable iff (rst)
		tx_launch |=> (!loop_tx) [*2])
		else $error("start bit not driven low");
	AST_RATE: assert property (@(posedge mclk) disable iff (rst)
		(q.cfg_s2[1:0] == 2'h3) |-> (div == DIV_9600))
		else $error("rate select mismatch");
endmodule
`default_nettype wire

// File: test/sln_link.sv
// Neighbouring loop node model: serial frame sender and receiver
`timescale 1ns/1ps
`default_nettype none
module sln_link
(
	input wire logic mclk,
	input wire logic line_in,
	output logic line_out
);
	// Cycles per bit, set by the bench for the chosen rate
	int div = 16;
	// Line idles high between frames
	initial line_out = 1'b1;
	// ==========================================================
	// Send one frame: low start, eight bits LSB first, high stop
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_out <= f[i];
			repeat (div) @(posedge mclk);
		end
	endtask
	// ==========================================================
	// Receive one frame; ok stays low on timeout or bad stop bit
	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (line_in !== 1'b0 && n < 2000)
		begin
			@(posedge mclk);
			n++;
		end
		if (n < 2000)
		begin
			// Sample in the middle of each bit
			repeat (div / 2) @(posedge mclk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (div) @(posedge mclk);
				b[i] = line_in;
			end
			repeat (div) @(posedge mclk);
			ok = (line_in === 1'b1);
		end
	endtask
endmodule
`default_nettype wire

// File: test/sln_node_bench.sv
// Bench for the serial loop node: routing, execution, command port, answer buffer
`timescale 1ns/1ps
`default_nettype none
module sln_node_bench;
	import sln_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] cfg_pins = 4'h0;
	logic cmd_valid = 1'b0;
	logic rsp_ready = 1'b0;
	sln_msg_s cmd_msg = '0;
	logic loop_rx;
	logic loop_tx;
	logic cmd_ready;
	logic rsp_valid;
	sln_rsp_s rsp_data;
	int err_total = 0;
	int n_checks = 0;
	int divs[4] = '{16, 20, 24, 28}; // Shortened bit periods per rate
	initial forever #2.5 mclk = ~mclk;
	sln_node #(.DIV_300(20'h10), .DIV_1200(20'h14), .DIV_4800(20'h18), .DIV_9600(20'h1C))
	sln_node_i (.mclk(mclk), .rst(rst), .cfg_pins(cfg_pins), .loop_rx(loop_rx),
		.loop_tx(loop_tx), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_msg(cmd_msg),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
	sln_link sln_link_i (.mclk(mclk), .line_in(loop_tx), .line_out(loop_rx));
	// ==========================================================
	// Shared helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic restart(input logic [3:0] cfg);
		@(posedge mclk);
		rst <= 1'b1;
		cfg_pins <= cfg;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		sln_link_i.div = divs[cfg[1:0]];
	endtask
	// Send ni bytes while collecting no bytes; gap after so the node is idle again
	task automatic xfer(input logic [23:0] m, input int ni, input int no,
		output logic [23:0] got, output logic ok);
		logic [7:0] b;
		logic k;
		got = '0;
		ok = 1'b1;
		fork
			for (int i = 0; i < ni; i++) sln_link_i.send_byte(m[23 - 8 * i -: 8]);
			for (int j = 0; j < no; j++)
			begin
				sln_link_i.recv_byte(b, k);
				got[23 - 8 * j -: 8] = b;
				ok &= k;
			end
		join
		repeat (sln_link_i.div) @(posedge mclk);
	endtask
	task automatic send_cmd(input logic [23:0] m);
		logic seen;
		@(posedge mclk);
		cmd_msg <= m;
		cmd_valid <= 1'b1;
		seen = 1'b0;
		while (!seen)
		begin
			@(negedge mclk);
			seen = (cmd_ready === 1'b1);
			@(posedge mclk);
		end
		cmd_valid <= 1'b0;
	endtask
	task automatic pop(input logic [14:0] exp);
		int n;
		@(negedge mclk);
		for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(negedge mclk);
		check("rsp_valid", rsp_valid, 1);
		check("rsp_data", {17'h0, rsp_data}, {17'h0, exp});
		@(posedge mclk);
		rsp_ready <= 1'b1;
		@(posedge mclk);
		rsp_ready <= 1'b0;
	endtask
	// ==========================================================
	// Slave forwarding at every rate, command port refused
	task automatic t_forward();
		logic [23:0] g;
		logic ok;
		for (int r = 0; r < 4; r++)
		begin
			restart({2'b00, r[1:0]});
			cmd_valid <= 1'b1;
			check("idle_line", loop_tx, 1);
			xfer(24'h0385A5, 3, 3, g, ok);
			check("fwd_write", {ok, g}, {1'b1, 24'h0285A5});
			xfer(24'h011100, 2, 2, g, ok);
			check("fwd_read", {ok, g}, {1'b1, 24'h001100});
			check("slave_ready", cmd_ready, 0);
			cmd_valid <= 1'b0;
		end
	endtask
	// Slave executes writes silently and answers reads
	task automatic t_exec();
		logic [23:0] g;
		logic ok;
		restart(4'h1);
		xfer(24'h00FF3C, 3, 1, g, ok);
		check("write_silent", ok, 0);
		xfer(24'h0080C3, 3, 1, g, ok);
		check("write_silent0", ok, 0);
		xfer(24'h007F00, 2, 3, g, ok);
		check("read_top", {ok, g}, {1'b1, 24'hFFFF3C});
		xfer(24'h000000, 2, 3, g, ok);
		check("read_zero", {ok, g}, {1'b1, 24'hFF80C3});
		xfer(24'h001000, 2, 3, g, ok);
		check("read_clear", {ok, g}, {1'b1, 24'hFF9000});
	endtask
	// Master injects commands and buffers answers while consumer stalls
	task automatic t_master();
		logic [23:0] g;
		logic ok;
		restart(4'h4);
		@(negedge mclk);
		check("master_ready", cmd_ready, 1);
		fork
			send_cmd(24'h028A5A);
			xfer(24'h0, 0, 3, g, ok);
		join
		check("inject", {ok, g}, {1'b1, 24'h028A5A});
		xfer(24'h000B00, 2, 0, g, ok);
		check("read_drop", rsp_valid, 0);
		xfer(24'hFF8A77, 3, 0, g, ok);
		xfer(24'hFF9155, 3, 0, g, ok);
		xfer(24'hFF9266, 3, 0, g, ok);
		pop({7'h0A, 8'h77});
		pop({7'h11, 8'h55});
		pop({7'h12, 8'h66});
		@(negedge mclk);
		check("drained", rsp_valid, 0);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		t_forward();
		t_exec();
		t_master();
		end_sim();
	end
	initial
	begin
		repeat (40000) @(posedge mclk);
		err_total++;
		end_sim();
	end
endmodule
`default_nettype wire
